// ---- csag_top.sv ----
// Clock-source event flags, their two interrupt lines and AHB clock gating.
// Assumes oscillator indications arrive asynchronously and are synchronised here.
`timescale 1ns/1ps

// How it works
// - Enable register writes apply only with key 0x5A5A in bits 31:16.
// - Enable bits 8 and 7 gate high/low external run-failure interrupts.
// - Enable bits 6 and 5 gate high/low external start-up failure interrupts.
// - Enable bits 4,3,1,0 gate stable interrupts; bit 2 reserved.
// - Run failures go to the fault line, other events to the global line.
// - Flag bits 15,14,12,11 show live stability, hardware only.
// - After reset flags read 0x801: high-speed internal stable status and flag.
// - Flag bits 8/7 set when an external oscillator stops while running.
// - Flag bits 6/5 set when an external oscillator start-up fails.
// - Flag bits 4,3,1,0 set when an oscillator becomes stable.
// - Writing 0 to clear bits 8:0 clears a flag; bits read as 1.
// - AHB bits 9,6,5,4 enable both clocks of four ports.
// - AHB bits 2 and 0 enable both clocks of checksum and DMA units.
// - AHB bit 1 enables only the flash configuration clock.
// - All AHB clock enables are zero after reset.
// - High-speed external check counts 8192/32768/131072/262144 cycles by selection.
module csag_top #(
    parameter int HS_WAIT_0 = csag_pkg::HS_WAIT_CYC0,
    parameter int HS_WAIT_1 = csag_pkg::HS_WAIT_CYC1,
    parameter int HS_WAIT_2 = csag_pkg::HS_WAIT_CYC2,
    parameter int HS_WAIT_3 = csag_pkg::HS_WAIT_CYC3,
    parameter int STARTUP_LIMIT = csag_pkg::STARTUP_LIMIT_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Register port.
    input wire csag_pkg::csag_bus_t bus,
    output logic [csag_pkg::DATA_W-1:0] rdata,
    // Oscillator indications and control.
    input wire csag_pkg::csag_osc_t osc,
    output logic hs_ext_osc_on,
    // Peripheral clock enables.
    output csag_pkg::csag_gate_t gate,
    // Interrupt lines.
    output logic fault_irq,
    output logic global_irq
);
    import csag_pkg::*;

    csag_state_t st_reg;
    csag_state_t st_next;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [OSC_CNT_W-1:0] wait_target;
    logic tick;
    logic wr_irq_en;
    logic key_ok;

    // Selected oscillator cycle target for the high-speed external check.
    always_comb begin
        case (st_reg.wait_sel)
            2'h0: wait_target = OSC_CNT_W'(HS_WAIT_0);
            2'h1: wait_target = OSC_CNT_W'(HS_WAIT_1);
            2'h2: wait_target = OSC_CNT_W'(HS_WAIT_2);
            default: wait_target = OSC_CNT_W'(HS_WAIT_3);
        endcase
    end

    // Decoded write conditions and the oscillator tick for the checks; key_ok and tick also feed the next-state logic.
    assign wr_irq_en = bus.wr && (bus.addr == OFS_IRQ_EN);
    assign key_ok = (bus.wdata[DATA_W-1:KEY_LSB] == IRQ_KEY);
    assign tick = st_reg.sync2.hs_ext_osc && !st_reg.prev.hs_ext_osc;

    // Next state of the whole block.
    always_comb begin
        st_next = st_reg;
        ev = '0;
        clr = '0;

        // Two-stage synchroniser; only the second stage feeds edge detection.
        st_next.sync1 = osc;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;

        // High-speed external start-up and run supervision.
        case (st_reg.hs_state)
            HS_OFF: begin
                st_next.osc_cnt = '0;
                st_next.time_cnt = '0;
                if (st_reg.hs_on) begin
                    st_next.hs_state = HS_COUNT;
                end
            end
            HS_COUNT: begin
                if (!st_reg.hs_on) begin
                    st_next.hs_state = HS_OFF;
                end else if (tick && (st_reg.osc_cnt == wait_target - 1'b1)) begin
                    st_next.hs_state = HS_RUN;
                    st_next.time_cnt = '0;
                    ev[BIT_HS_EXT_RDY] = 1'b1;
                end else if (st_reg.time_cnt == TIME_CNT_W'(STARTUP_LIMIT - 1)) begin
                    st_next.hs_state = HS_HALT;
                    ev[BIT_HS_START_FAIL] = 1'b1;
                end else begin
                    st_next.time_cnt = st_reg.time_cnt + 1'b1;
                    if (tick) begin
                        st_next.osc_cnt = st_reg.osc_cnt + 1'b1;
                    end
                end
            end
            HS_RUN: begin
                if (!st_reg.hs_on) begin
                    st_next.hs_state = HS_OFF;
                end else if (tick) begin
                    st_next.time_cnt = '0;
                end else if (st_reg.time_cnt == TIME_CNT_W'(RUN_MISS_CYC - 1)) begin
                    st_next.hs_state = HS_HALT;
                    ev[BIT_HS_RUN_FAIL] = 1'b1;
                end else begin
                    st_next.time_cnt = st_reg.time_cnt + 1'b1;
                end
            end
            HS_HALT: begin
                // A failed oscillator waits for software to switch it off first.
                if (!st_reg.hs_on) begin
                    st_next.hs_state = HS_OFF;
                end
            end
            default: begin
                st_next.hs_state = HS_OFF;
            end
        endcase

        ev[BIT_LS_EXT_RDY] = st_reg.sync2.ls_ext_stable && !st_reg.prev.ls_ext_stable;
        ev[BIT_LS_INT_RDY] = st_reg.sync2.ls_int_stable && !st_reg.prev.ls_int_stable;
        ev[BIT_HS_INT_RDY] = st_reg.sync2.hs_int_stable && !st_reg.prev.hs_int_stable;
        ev[BIT_LS_RUN_FAIL] = st_reg.sync2.ls_ext_run_fail && !st_reg.prev.ls_ext_run_fail;
        ev[BIT_LS_START_FAIL] = st_reg.sync2.ls_ext_startup_fail
            && !st_reg.prev.ls_ext_startup_fail;

        st_next.live[3] = st_reg.sync2.ls_ext_stable;
        st_next.live[2] = st_reg.sync2.ls_int_stable;
        st_next.live[1] = (st_reg.hs_state == HS_RUN);
        st_next.live[0] = st_reg.sync2.hs_int_stable;

        // Register writes.
        if (bus.wr) begin
            case (bus.addr)
                OFS_IRQ_EN: begin
                    if (key_ok) begin
                        st_next.irq_en = bus.wdata[EV_W-1:0] & EVENT_MASK;
                    end
                end
                OFS_CLEAR: begin
                    clr = ~bus.wdata[EV_W-1:0] & EVENT_MASK;
                end
                OFS_HS_CTRL: begin
                    st_next.hs_on = bus.wdata[BIT_HS_ON];
                    st_next.wait_sel = bus.wdata[WAIT_LSB+1:WAIT_LSB];
                end
                OFS_AHB: begin
                    st_next.gate.port_f_clock_en = bus.wdata[BIT_PORT_F];
                    st_next.gate.port_c_clock_en = bus.wdata[BIT_PORT_C];
                    st_next.gate.port_b_clock_en = bus.wdata[BIT_PORT_B];
                    st_next.gate.port_a_clock_en = bus.wdata[BIT_PORT_A];
                    st_next.gate.crc_clock_en = bus.wdata[BIT_CRC];
                    st_next.gate.dma_clock_en = bus.wdata[BIT_DMA];
                    st_next.gate.flash_cfg_clock_en = bus.wdata[BIT_FLASH];
                end
                default: begin
                end
            endcase
        end

        st_next.flags = (st_reg.flags & ~clr) | ev;

        st_next.fault_irq = |(st_next.flags & st_next.irq_en & FAULT_MASK);
        st_next.global_irq = |(st_next.flags & st_next.irq_en & GLOBAL_MASK);

        // Read data stand only in the cycle after the strobe; unmapped reads zero.
        st_next.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                OFS_IRQ_EN: st_next.rdata = {{(DATA_W-EV_W){1'b0}}, st_reg.irq_en};
                OFS_FLAGS: begin
                    st_next.rdata[EV_W-1:0] = st_reg.flags;
                    st_next.rdata[BIT_LS_EXT_LIVE] = st_reg.live[3];
                    st_next.rdata[BIT_LS_INT_LIVE] = st_reg.live[2];
                    st_next.rdata[BIT_HS_EXT_LIVE] = st_reg.live[1];
                    st_next.rdata[BIT_HS_INT_LIVE] = st_reg.live[0];
                end
                OFS_CLEAR: st_next.rdata = CLEAR_READ;
                OFS_HS_CTRL: begin
                    st_next.rdata[BIT_HS_ON] = st_reg.hs_on;
                    st_next.rdata[WAIT_LSB+1:WAIT_LSB] = st_reg.wait_sel;
                end
                OFS_AHB: begin
                    st_next.rdata[BIT_PORT_F] = st_reg.gate.port_f_clock_en;
                    st_next.rdata[BIT_PORT_C] = st_reg.gate.port_c_clock_en;
                    st_next.rdata[BIT_PORT_B] = st_reg.gate.port_b_clock_en;
                    st_next.rdata[BIT_PORT_A] = st_reg.gate.port_a_clock_en;
                    st_next.rdata[BIT_CRC] = st_reg.gate.crc_clock_en;
                    st_next.rdata[BIT_FLASH] = st_reg.gate.flash_cfg_clock_en;
                    st_next.rdata[BIT_DMA] = st_reg.gate.dma_clock_en;
                end
                default: st_next.rdata = '0;
            endcase
        end
    end

    // State register; the synchroniser resets to the idle oscillator levels.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg.sync1 <= OSC_RST;
            st_reg.sync2 <= OSC_RST;
            st_reg.prev <= OSC_RST;
            st_reg.irq_en <= IRQ_EN_RST;
            st_reg.flags <= FLAGS_EV_RST;
            st_reg.live <= LIVE_RST;
            st_reg.gate <= AHB_RST;
            st_reg.hs_on <= 1'b0;
            st_reg.wait_sel <= WAIT_SEL_RST;
            st_reg.hs_state <= HS_OFF;
            st_reg.osc_cnt <= '0;
            st_reg.time_cnt <= '0;
            st_reg.rdata <= '0;
            st_reg.fault_irq <= 1'b0;
            st_reg.global_irq <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register.
    assign rdata = st_reg.rdata;
    assign gate = st_reg.gate;
    assign fault_irq = st_reg.fault_irq;
    assign global_irq = st_reg.global_irq;
    assign hs_ext_osc_on = st_reg.hs_on;

    // Checks on the design's own behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    key_reject_a: assert property (
        wr_irq_en && !key_ok |=> st_reg.irq_en == $past(st_reg.irq_en))
        else $error("enable register changed without the key");

    key_accept_a: assert property (
        wr_irq_en && key_ok |=> st_reg.irq_en == ($past(bus.wdata[EV_W-1:0]) & EVENT_MASK))
        else $error("keyed enable write not applied");

    reserved_en_a: assert property (
        st_reg.irq_en[2] == 1'b0 && st_reg.flags[2] == 1'b0)
        else $error("reserved enable or flag bit set");

    fault_route_a: assert property (
        (ev & FAULT_MASK) != '0 && (st_reg.irq_en & ev & FAULT_MASK) != '0
        && !wr_irq_en |=> fault_irq)
        else $error("enabled run failure did not raise the fault line");

    global_level_a: assert property (
        global_irq == |(st_reg.flags & st_reg.irq_en & GLOBAL_MASK))
        else $error("global line does not follow enabled flags");

    set_wins_a: assert property (
        bus.wr && bus.addr == OFS_CLEAR && ev[BIT_LS_INT_RDY] |=> st_reg.flags[BIT_LS_INT_RDY])
        else $error("event lost against a clear");

    clear_zero_a: assert property (
        bus.wr && bus.addr == OFS_CLEAR && !bus.wdata[BIT_HS_INT_RDY] && !ev[BIT_HS_INT_RDY]
        |=> !st_reg.flags[BIT_HS_INT_RDY])
        else $error("writing zero did not clear the flag");

    hs_fail_a: assert property (
        st_reg.hs_state == HS_COUNT && st_reg.hs_on && !tick
        && st_reg.time_cnt == TIME_CNT_W'(STARTUP_LIMIT - 1)
        |=> st_reg.flags[BIT_HS_START_FAIL] && st_reg.hs_state == HS_HALT)
        else $error("start-up timeout did not raise its flag");

    ahb_write_a: assert property (
        bus.wr && bus.addr == OFS_AHB |=> gate.port_f_clock_en == $past(bus.wdata[BIT_PORT_F])
        && gate.dma_clock_en == $past(bus.wdata[BIT_DMA]))
        else $error("AHB clock enable write not applied");

    read_flags_a: assert property (
        bus.rd && bus.addr == OFS_FLAGS |=> rdata[BIT_HS_INT_LIVE] == $past(st_reg.live[0])
        ##1 rdata == '0 || $past(bus.rd))
        else $error("flag read data wrong or held too long");

    // Event capture, live status and gating; the bench reaches every antecedent below.
    fault_level_a: assert property (
        fault_irq == |(st_reg.flags & st_reg.irq_en & FAULT_MASK))
        else $error("fault line does not follow enabled run failures");

    ls_int_ready_a: assert property (
        st_reg.sync2.ls_int_stable && !st_reg.prev.ls_int_stable
        |=> st_reg.flags[BIT_LS_INT_RDY])
        else $error("low-speed internal stable edge did not set its flag");

    ls_run_fail_a: assert property (
        st_reg.sync2.ls_ext_run_fail && !st_reg.prev.ls_ext_run_fail
        |=> st_reg.flags[BIT_LS_RUN_FAIL])
        else $error("low-speed run failure edge did not set its flag");

    ls_start_fail_a: assert property (
        st_reg.sync2.ls_ext_startup_fail && !st_reg.prev.ls_ext_startup_fail
        |=> st_reg.flags[BIT_LS_START_FAIL])
        else $error("low-speed start-up failure edge did not set its flag");

    live_no_clear_a: assert property (
        bus.wr && bus.addr == OFS_CLEAR
        |=> st_reg.live[2] == $past(st_reg.sync2.ls_int_stable))
        else $error("live status bit disturbed by a clear write");

    hs_int_live_a: assert property (
        st_reg.live[0] == $past(st_reg.sync2.hs_int_stable))
        else $error("high-speed internal live bit does not follow its input");

    early_run_a: assert property (
        st_reg.hs_state == HS_COUNT && st_reg.osc_cnt < wait_target - 1'b1
        |=> st_reg.hs_state != HS_RUN)
        else $error("high-speed external declared stable before its count");

    hs_ready_a: assert property (
        st_reg.hs_state == HS_COUNT && st_reg.hs_on && tick
        && st_reg.osc_cnt == wait_target - 1'b1
        |=> st_reg.hs_state == HS_RUN && st_reg.flags[BIT_HS_EXT_RDY])
        else $error("completed count did not raise the stable flag");

    hs_run_fail_a: assert property (
        st_reg.hs_state == HS_RUN && st_reg.hs_on && !tick
        && st_reg.time_cnt == TIME_CNT_W'(RUN_MISS_CYC - 1)
        |=> st_reg.flags[BIT_HS_RUN_FAIL] && st_reg.hs_state == HS_HALT)
        else $error("stopped oscillator did not raise the run failure flag");

    clear_ones_a: assert property (
        bus.wr && bus.addr == OFS_CLEAR && bus.wdata[BIT_LS_INT_RDY]
        && st_reg.flags[BIT_LS_INT_RDY] |=> st_reg.flags[BIT_LS_INT_RDY])
        else $error("writing one to a clear bit removed the flag");

    crc_gate_a: assert property (
        bus.wr && bus.addr == OFS_AHB |=> gate.crc_clock_en == $past(bus.wdata[BIT_CRC]))
        else $error("checksum clock enable write not applied");

    flash_gate_a: assert property (
        bus.wr && bus.addr == OFS_AHB |=> gate.flash_cfg_clock_en == $past(bus.wdata[BIT_FLASH]))
        else $error("flash configuration clock enable write not applied");

    gate_hold_a: assert property (
        !(bus.wr && bus.addr == OFS_AHB) |=> gate == $past(gate))
        else $error("clock enables changed without a write");

    fault_rise_c: cover property ($rose(fault_irq));
    global_rise_c: cover property ($rose(global_irq));
    hs_run_c: cover property (st_reg.hs_state == HS_COUNT ##1 st_reg.hs_state == HS_RUN);
    key_miss_c: cover property (wr_irq_en && !key_ok);
    hs_halt_c: cover property (st_reg.hs_state == HS_HALT);

endmodule : csag_top

// ---- csag_pkg.sv ----
// Shared constants and types of the clock-source event and AHB gating block.
// Assumes a single 100 MHz system clock and a simple strobe-based register port.
package csag_pkg;

    // Register port geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_HS_CTRL = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_AHB = 8'h30;

    // Unlock key carried in the upper half of an enable register write.
    localparam int KEY_LSB = 16;
    localparam logic [15:0] IRQ_KEY = 16'h5A5A;

    // Event bit positions shared by enable, flag and clear registers.
    localparam int EV_W = 9;
    localparam int BIT_HS_RUN_FAIL = 8;
    localparam int BIT_LS_RUN_FAIL = 7;
    localparam int BIT_HS_START_FAIL = 6;
    localparam int BIT_LS_START_FAIL = 5;
    localparam int BIT_LS_EXT_RDY = 4;
    localparam int BIT_LS_INT_RDY = 3;
    localparam int BIT_HS_EXT_RDY = 1;
    localparam int BIT_HS_INT_RDY = 0;
    localparam logic [EV_W-1:0] EVENT_MASK = 9'h1FB;
    localparam logic [EV_W-1:0] FAULT_MASK = 9'h180;
    localparam logic [EV_W-1:0] GLOBAL_MASK = 9'h07B;

    // Live stable status positions in the flag register.
    localparam int BIT_LS_EXT_LIVE = 15;
    localparam int BIT_LS_INT_LIVE = 14;
    localparam int BIT_HS_EXT_LIVE = 12;
    localparam int BIT_HS_INT_LIVE = 11;

    // Reset values.
    localparam logic [EV_W-1:0] IRQ_EN_RST = 9'h000;
    localparam logic [EV_W-1:0] FLAGS_EV_RST = 9'h001;
    localparam logic [3:0] LIVE_RST = 4'h1;
    localparam logic [DATA_W-1:0] FLAGS_RST = 32'h0000_0801;
    localparam logic [DATA_W-1:0] CLEAR_READ = 32'h0000_01FF;
    localparam logic [6:0] AHB_RST = 7'h00;
    localparam logic [5:0] OSC_RST = 6'h01;

    // AHB enable bit positions.
    localparam int BIT_PORT_F = 9;
    localparam int BIT_PORT_C = 6;
    localparam int BIT_PORT_B = 5;
    localparam int BIT_PORT_A = 4;
    localparam int BIT_CRC = 2;
    localparam int BIT_FLASH = 1;
    localparam int BIT_DMA = 0;

    // High-speed external control register fields.
    localparam int BIT_HS_ON = 0;
    localparam int WAIT_LSB = 4;
    localparam logic [1:0] WAIT_SEL_RST = 2'h0;

    // Oscillator cycles counted before a stable verdict, per selection.
    localparam int HS_WAIT_CYC0 = 8192;
    localparam int HS_WAIT_CYC1 = 32768;
    localparam int HS_WAIT_CYC2 = 131072;
    localparam int HS_WAIT_CYC3 = 262144;
    localparam int OSC_CNT_W = 19;

    // Timing limits in their own units and as system clock cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int STARTUP_LIMIT_MS = 65;
    localparam int STARTUP_LIMIT_CYC = STARTUP_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RUN_MISS_NS = 1000;
    localparam int RUN_MISS_CYC = RUN_MISS_NS / CLK_PERIOD_NS;
    localparam int TIME_CNT_W = 24;

    // Register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } csag_bus_t;

    // Raw oscillator indications from the analog side.
    typedef struct packed {
        logic hs_ext_osc;
        logic ls_ext_run_fail;
        logic ls_ext_startup_fail;
        logic ls_int_stable;
        logic ls_ext_stable;
        logic hs_int_stable;
    } csag_osc_t;

    // AHB clock enables; each covers both clocks except flash (config only).
    typedef struct packed {
        logic port_f_clock_en;
        logic port_c_clock_en;
        logic port_b_clock_en;
        logic port_a_clock_en;
        logic crc_clock_en;
        logic flash_cfg_clock_en;
        logic dma_clock_en;
    } csag_gate_t;

    typedef enum logic [1:0] {HS_OFF, HS_COUNT, HS_RUN, HS_HALT} csag_hs_state_t;

    // Whole state of the block.
    typedef struct packed {
        csag_osc_t sync1;
        csag_osc_t sync2;
        csag_osc_t prev;
        logic [EV_W-1:0] irq_en;
        logic [EV_W-1:0] flags;
        logic [3:0] live;
        csag_gate_t gate;
        logic hs_on;
        logic [1:0] wait_sel;
        csag_hs_state_t hs_state;
        logic [OSC_CNT_W-1:0] osc_cnt;
        logic [TIME_CNT_W-1:0] time_cnt;
        logic [DATA_W-1:0] rdata;
        logic fault_irq;
        logic global_irq;
    } csag_state_t;

endpackage : csag_pkg

// ---- tb_csag_top.sv ----
// Self-checking bench for the clock-source event flags, interrupts and AHB gating.
// Assumes the csag_pkg package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module tb_csag_top;
    import csag_pkg::*;

    logic clk;
    logic rst_b;
    csag_bus_t bus;
    csag_osc_t osc;
    logic [DATA_W-1:0] rdata;
    logic hs_ext_osc_on;
    csag_gate_t gate;
    logic fault_irq;
    logic global_irq;
    int fails;
    int compares;
    logic [DATA_W-1:0] rd_val;

    // Small check counts keep the high-speed external runs short.
    csag_top #(.HS_WAIT_0(4), .HS_WAIT_1(8), .HS_WAIT_2(16), .HS_WAIT_3(32),
        .STARTUP_LIMIT(400)) csag_top_i (
        .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .osc(osc),
        .hs_ext_osc_on(hs_ext_osc_on), .gate(gate), .fault_irq(fault_irq),
        .global_irq(global_irq));

    // Free-running 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("Checks made %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // One-cycle write strobe; the register updates at the sampling edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe edge, so sample there.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : rd

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(what, exp, rd_val);
    endtask : rd_chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    // Oscillator ticks with a four-cycle period, slow enough for the synchroniser.
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            osc.hs_ext_osc <= 1'b1;
            repeat (2) @(posedge clk);
            osc.hs_ext_osc <= 1'b0;
            @(posedge clk);
        end
    endtask : ticks

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
    endtask : do_reset

    task automatic test_reset_values();
        rd_chk("flags after reset", OFS_FLAGS, 32'h0000_0801);
        rd_chk("enable after reset", OFS_IRQ_EN, 32'h0000_0000);
        rd_chk("clear reads ones", OFS_CLEAR, 32'h0000_01FF);
        rd_chk("ahb after reset", OFS_AHB, 32'h0000_0000);
        chk("gate after reset", 32'h0, {25'h0, gate});
        rd_chk("unmapped read", 8'h40, 32'h0000_0000);
    endtask : test_reset_values

    task automatic test_ahb_gating();
        wr(OFS_AHB, 32'h0000_0251);
        wait_cyc(1);
        chk("gate ports f c a dma", 32'h69, {25'h0, gate});
        rd_chk("ahb readback", OFS_AHB, 32'h0000_0251);
        wr(OFS_AHB, 32'h0000_0026);
        wait_cyc(1);
        chk("gate port b crc flash", 32'h16, {25'h0, gate});
        chk("flash config only", 32'h1, {31'h0, gate.flash_cfg_clock_en});
    endtask : test_ahb_gating

    task automatic test_key_and_enable();
        wr(OFS_IRQ_EN, 32'h5A5B_01FB);
        rd_chk("enable with bad key", OFS_IRQ_EN, 32'h0000_0000);
        chk("no irq without enable", 32'h0, {31'h0, global_irq});
        wr(OFS_IRQ_EN, 32'h5A5A_01FB);
        rd_chk("enable with key", OFS_IRQ_EN, 32'h0000_01FB);
        chk("reset flag routed global", 32'h1, {31'h0, global_irq});
        chk("fault line quiet", 32'h0, {31'h0, fault_irq});
        wr(OFS_IRQ_EN, 32'h5A5A_0000);
        wait_cyc(2);
        chk("global off when disabled", 32'h0, {31'h0, global_irq});
    endtask : test_key_and_enable

    task automatic test_stable_events();
        wr(OFS_IRQ_EN, 32'h5A5A_0008);
        wr(OFS_CLEAR, 32'h0000_01FE);
        rd_chk("hs int flag cleared", OFS_FLAGS, 32'h0000_0800);
        @(posedge clk);
        osc.ls_int_stable <= 1'b1;
        // set beats clear: the clear strobe meets the edge that captures the event.
        @(posedge clk);
        wr(OFS_CLEAR, 32'h0000_01F7);
        wait_cyc(2);
        rd_chk("ls int stable flags", OFS_FLAGS, 32'h0000_4808);
        chk("global on ls int", 32'h1, {31'h0, global_irq});
        wr(OFS_CLEAR, 32'h0000_01FF);
        rd_chk("writing ones keeps flags", OFS_FLAGS, 32'h0000_4808);
        wr(OFS_CLEAR, 32'h0000_01F7);
        rd_chk("live bit survives clear", OFS_FLAGS, 32'h0000_4800);
        chk("global off after clear", 32'h0, {31'h0, global_irq});
    endtask : test_stable_events

    task automatic test_low_speed_faults();
        wr(OFS_IRQ_EN, 32'h5A5A_00A0);
        osc.ls_ext_run_fail <= 1'b1;
        wait_cyc(5);
        chk("run fail on fault line", 32'h1, {31'h0, fault_irq});
        chk("run fail not global", 32'h0, {31'h0, global_irq});
        @(posedge clk);
        osc.ls_ext_startup_fail <= 1'b1;
        wait_cyc(5);
        chk("start fail on global", 32'h1, {31'h0, global_irq});
        rd_chk("ls fault flags", OFS_FLAGS, 32'h0000_48A0);
        wr(OFS_CLEAR, 32'h0000_015F);
        rd_chk("ls faults cleared", OFS_FLAGS, 32'h0000_4800);
        chk("both lines low", 32'h0, {30'h0, fault_irq, global_irq});
    endtask : test_low_speed_faults

    task automatic test_hs_external();
        wr(OFS_IRQ_EN, 32'h5A5A_0142);
        wr(OFS_HS_CTRL, 32'h0000_0011);
        wait_cyc(1);
        chk("hs ext switched on", 32'h1, {31'h0, hs_ext_osc_on});
        ticks(6);
        rd_chk("not stable before count", OFS_FLAGS, 32'h0000_4800);
        ticks(4);
        rd_chk("hs ext stable", OFS_FLAGS, 32'h0000_5802);
        chk("hs stable on global", 32'h1, {31'h0, global_irq});
        wait_cyc(120);
        rd_chk("hs ext stopped", OFS_FLAGS, 32'h0000_4902);
        chk("hs run fail on fault", 32'h1, {31'h0, fault_irq});
        wr(OFS_HS_CTRL, 32'h0000_0000);
        wr(OFS_CLEAR, 32'h0000_00FD);
        wr(OFS_HS_CTRL, 32'h0000_0021);
        wait_cyc(420);
        rd_chk("hs start-up failed", OFS_FLAGS, 32'h0000_4840);
        chk("hs start fail global", 32'h1, {31'h0, global_irq});
        wr(OFS_HS_CTRL, 32'h0000_0000);
        wr(OFS_CLEAR, 32'h0000_01BF);
        wait_cyc(1);
        chk("hs start fail cleared", 32'h0, {30'h0, fault_irq, global_irq});
        // longest selection: 32 ticks are needed, so 30 must not be enough.
        wr(OFS_HS_CTRL, 32'h0000_0031);
        rd_chk("hs ctrl readback", OFS_HS_CTRL, 32'h0000_0031);
        ticks(30);
        rd_chk("longest count not done", OFS_FLAGS, 32'h0000_4800);
        ticks(4);
        rd_chk("longest count done", OFS_FLAGS, 32'h0000_5802);
        wr(OFS_HS_CTRL, 32'h0000_0000);
    endtask : test_hs_external

    // Main sequence, with a second reset in mid-run at the end.
    initial begin
        fails = 0;
        compares = 0;
        rst_b = 1'b0;
        bus = '0;
        osc = '0;
        osc.hs_int_stable = 1'b1;
        do_reset();
        test_reset_values();
        test_ahb_gating();
        test_key_and_enable();
        test_stable_events();
        test_low_speed_faults();
        test_hs_external();
        @(posedge clk);
        osc.ls_int_stable <= 1'b0;
        osc.ls_ext_run_fail <= 1'b0;
        osc.ls_ext_startup_fail <= 1'b0;
        do_reset();
        test_reset_values();
        tally_and_finish();
    end

    // Watchdog well past the expected run of under a thousand cycles.
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end

endmodule : tb_csag_top
